/* rtl/mhr_pkg.sv */
// Constants and types shared by the holding-register slave.
package mhr_pkg;
   // ==========================================================================
   // Function codes and diagnostic subcodes
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WRITE_ONE = 8'h06;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WRITE_MANY = 8'h10;
   localparam logic [7:0] FC_READ_WRITE = 8'h17;
   localparam logic [15:0] SUB_ECHO = 16'h0000;
   localparam logic [15:0] SUB_RESTART = 16'h0001;
   localparam logic [15:0] SUB_LISTEN = 16'h0004;
   // ==========================================================================
   // Exception codes
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [15:0] MAX_QTY = 16'h0078;
   // ==========================================================================
   // Register numbers (full 4xxxx numbers)
   localparam logic [16:0] REG_BASE = 17'h09C40;
   localparam logic [16:0] REG_CONTROL = 17'h09C41;
   localparam logic [16:0] REG_REF_ONE = 17'h09C42;
   localparam logic [16:0] REG_REF_TWO = 17'h09C43;
   localparam logic [16:0] REG_STATUS = 17'h09C44;
   localparam logic [16:0] REG_ACT_FIRST = 17'h09C45;
   localparam logic [16:0] REG_ACT_LAST = 17'h09C4C;
   localparam logic [16:0] REG_WCTRL_LO = 17'h09C5F;
   localparam logic [16:0] REG_WCTRL_HI = 17'h09C60;
   localparam logic [16:0] REG_WSTAT_LO = 17'h09C61;
   localparam logic [16:0] REG_WSTAT_HI = 17'h09C62;
   localparam logic [16:0] REG_PAR_FIRST = 17'h09CA5;
   localparam logic [16:0] REG_PAR_LAST = 17'h0C34F;
   localparam logic [16:0] PAR_PER_GROUP = 17'h00064;
   // ==========================================================================
   // Parameters served or watched inside the block
   localparam logic [13:0] PAR_LAST_EXC = 14'h14C6;
   localparam logic [13:0] PAR_CW_MIRROR = 14'h14C7;
   localparam logic [13:0] PAR_SW_MIRROR = 14'h14C8;
   localparam logic [13:0] PAR_SAVE = 14'h0647;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // ==========================================================================
   // Types
   typedef enum logic [1:0] {PROF_LIMITED, PROF_FULL, PROF_WIDE, PROF_NONE} mhr_profile_e;
   typedef enum logic [3:0] {K_CW, K_REFERENCE_ONE, K_REFERENCE_TWO, K_SW, K_ACT, K_WCL, K_WCH, K_WSL, K_WSH,
                             K_PAR, K_BAD} mhr_kind_e;
endpackage : mhr_pkg

/* rtl/mhr_slave.sv */
// Function-code interpreter and holding-register map of the fieldbus slave.
`timescale 1ns/1ns
module mhr_slave (
   input wire logic i_ref_clk, // 10 MHz clock
   input wire logic i_rst, // Synchronous reset
   input wire logic i_req_valid, // Decoded request present
   input wire logic [7:0] i_req_func, // Function code
   input wire logic [15:0] i_req_rd_addr, // Read start address
   input wire logic [15:0] i_req_rd_qty, // Read quantity
   input wire logic [15:0] i_req_wr_addr, // Write start address
   input wire logic [15:0] i_req_wr_qty, // Write quantity
   input wire logic [15:0] i_req_diag_sub, // Diagnostic subcode
   input wire logic [15:0] i_req_diag_data, // Diagnostic data field
   output logic o_req_ready, // Idle, request taken
   input wire logic i_wdata_valid, // Write word present
   input wire logic [15:0] i_wdata, // Write word
   output logic o_wdata_ready, // Write word taken
   output logic o_rd_valid, // Read word strobe
   output logic [15:0] o_rd_data, // Read word
   output logic o_rsp_valid, // Response strobe
   output logic [7:0] o_rsp_func, // Function answered
   output logic [7:0] o_rsp_exc, // Exception code, zero if normal
   output logic [15:0] o_rsp_data, // Diagnostic echo data
   output logic o_comm_restart, // Port restart, counter clear pulse
   output logic o_listen_only, // Listen-only mode
   output logic [7:0] o_last_exception_code, // Most recent exception
   input wire logic [1:0] i_comm_profile_select, // Active profile
   input wire logic [15:0] i_status_word, // 16-bit status
   input wire logic [31:0] i_wide_status, // 32-bit status
   input wire logic [127:0] i_actual_values, // Eight selected actual values
   output logic [15:0] o_control_word, // 16-bit control word
   output logic [15:0] o_reference_one, // Reference one
   output logic [15:0] o_reference_two, // Reference two
   output logic [31:0] o_wide_control, // 32-bit control word
   output logic [13:0] o_par_num, // Parameter number looked up
   input wire logic i_par_exists, // Parameter exists
   input wire logic i_par_read_only, // Parameter read-only
   input wire logic [15:0] i_par_rdata, // Parameter value
   output logic o_par_wr, // Volatile parameter write pulse
   output logic [15:0] o_par_wdata, // Parameter write value
   output logic o_parameter_save // Commit to permanent store pulse
);
   // ==========================================================================
   // Register decode
   function automatic mhr_pkg::mhr_kind_e mhr_kind(input logic [16:0] n, input logic [1:0] p);
      logic sixteen;
      logic wide;
      sixteen = (p == mhr_pkg::PROF_LIMITED) || (p == mhr_pkg::PROF_FULL);
      wide = (p == mhr_pkg::PROF_WIDE);
      mhr_kind = mhr_pkg::K_BAD;
      if (n == mhr_pkg::REG_CONTROL && sixteen) mhr_kind = mhr_pkg::K_CW;
      else if (n == mhr_pkg::REG_REF_ONE) mhr_kind = mhr_pkg::K_REFERENCE_ONE;
      else if (n == mhr_pkg::REG_REF_TWO) mhr_kind = mhr_pkg::K_REFERENCE_TWO;
      else if (n == mhr_pkg::REG_STATUS && sixteen) mhr_kind = mhr_pkg::K_SW;
      else if (n >= mhr_pkg::REG_ACT_FIRST && n <= mhr_pkg::REG_ACT_LAST) mhr_kind = mhr_pkg::K_ACT;
      else if (n == mhr_pkg::REG_WCTRL_LO && wide) mhr_kind = mhr_pkg::K_WCL;
      else if (n == mhr_pkg::REG_WCTRL_HI && wide) mhr_kind = mhr_pkg::K_WCH;
      else if (n == mhr_pkg::REG_WSTAT_LO && wide) mhr_kind = mhr_pkg::K_WSL;
      else if (n == mhr_pkg::REG_WSTAT_HI && wide) mhr_kind = mhr_pkg::K_WSH;
      else if (n >= mhr_pkg::REG_PAR_FIRST && n <= mhr_pkg::REG_PAR_LAST
               && ((n - mhr_pkg::REG_BASE) % mhr_pkg::PAR_PER_GROUP) != 17'h00000) begin
         mhr_kind = mhr_pkg::K_PAR;
      end
   endfunction : mhr_kind

   function automatic logic [16:0] mhr_reg_num(input logic [15:0] a);
      mhr_reg_num = {1'b0, a} + mhr_pkg::REG_BASE + 17'h00001;
   endfunction : mhr_reg_num

   function automatic logic qty_ok(input logic [15:0] q);
      qty_ok = (q != 16'h0000) && (q <= mhr_pkg::MAX_QTY);
   endfunction : qty_ok

   typedef enum logic [2:0] {S_IDLE, S_WR, S_RD, S_RSP, S_RESTART} mhr_state_e;
   mhr_state_e state_q;
   logic ph_q;
   logic rd_pend_q;
   logic restart_pend_q;
   logic [16:0] cur_q;
   logic [15:0] cnt_q;
   logic [16:0] rd_start_q;
   logic [15:0] rd_cnt_q;
   logic [7:0] exc_q;

   // ==========================================================================
   // Per-word access check
   mhr_pkg::mhr_kind_e kind;
   logic [13:0] pnum;
   logic [2:0] act_idx;
   logic mirror;
   logic [7:0] wr_err;
   logic [7:0] rd_err;
   logic [15:0] rdata;
   logic wr_fire;

   always_comb begin
      kind = mhr_kind(cur_q, i_comm_profile_select);
      pnum = 14'(cur_q - mhr_pkg::REG_BASE);
      act_idx = 3'(cur_q - mhr_pkg::REG_ACT_FIRST);
      mirror = (pnum == mhr_pkg::PAR_LAST_EXC) || (pnum == mhr_pkg::PAR_CW_MIRROR)
               || (pnum == mhr_pkg::PAR_SW_MIRROR);
      rd_err = mhr_pkg::EXC_NONE;
      if (kind == mhr_pkg::K_BAD || (kind == mhr_pkg::K_PAR && !mirror && !i_par_exists)) begin
         rd_err = mhr_pkg::EXC_ADDR;
      end
      wr_err = rd_err;
      if (rd_err == mhr_pkg::EXC_NONE && (kind == mhr_pkg::K_SW || kind == mhr_pkg::K_ACT
          || kind == mhr_pkg::K_WSL || kind == mhr_pkg::K_WSH
          || (kind == mhr_pkg::K_PAR && (mirror || i_par_read_only)))) begin
         wr_err = mhr_pkg::EXC_VALUE;
      end
      unique case (kind)
         mhr_pkg::K_CW: rdata = o_control_word;
         mhr_pkg::K_REFERENCE_ONE: rdata = o_reference_one;
         mhr_pkg::K_REFERENCE_TWO: rdata = o_reference_two;
         mhr_pkg::K_SW: rdata = i_status_word;
         mhr_pkg::K_ACT: rdata = i_actual_values[act_idx * 16 +: 16];
         mhr_pkg::K_WCL: rdata = o_wide_control[15:0];
         mhr_pkg::K_WCH: rdata = o_wide_control[31:16];
         mhr_pkg::K_WSL: rdata = i_wide_status[15:0];
         mhr_pkg::K_WSH: rdata = i_wide_status[31:16];
         mhr_pkg::K_PAR: begin
            if (pnum == mhr_pkg::PAR_LAST_EXC) rdata = {8'h00, o_last_exception_code};
            else if (pnum == mhr_pkg::PAR_CW_MIRROR) rdata = o_control_word;
            else if (pnum == mhr_pkg::PAR_SW_MIRROR) rdata = i_status_word;
            else rdata = i_par_rdata;
         end
         default: rdata = mhr_pkg::RESET_WORD;
      endcase
      wr_fire = (state_q == S_WR) && ph_q && i_wdata_valid && (wr_err == mhr_pkg::EXC_NONE);
   end

   // ==========================================================================
   // Transaction sequencing
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state_q <= S_IDLE;
         ph_q <= 1'b0;
         rd_pend_q <= 1'b0;
         restart_pend_q <= 1'b0;
         cur_q <= 17'h00000;
         cnt_q <= 16'h0000;
         rd_start_q <= 17'h00000;
         rd_cnt_q <= 16'h0000;
         exc_q <= mhr_pkg::EXC_NONE;
         o_req_ready <= 1'b0;
         o_wdata_ready <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= mhr_pkg::RESET_WORD;
         o_rsp_valid <= 1'b0;
         o_rsp_func <= 8'h00;
         o_rsp_exc <= mhr_pkg::EXC_NONE;
         o_rsp_data <= mhr_pkg::RESET_WORD;
         o_comm_restart <= 1'b0;
         o_listen_only <= 1'b0;
         o_last_exception_code <= mhr_pkg::EXC_NONE;
         o_par_num <= 14'h0000;
      end else begin
         o_rd_valid <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_comm_restart <= 1'b0;
         o_req_ready <= 1'b0;
         o_par_num <= pnum;
         unique case (state_q)
            S_IDLE: begin
               o_req_ready <= 1'b1;
               exc_q <= mhr_pkg::EXC_NONE;
               rd_pend_q <= 1'b0;
               restart_pend_q <= 1'b0;
               ph_q <= 1'b0;
               if (i_req_valid && o_req_ready) begin
                  o_req_ready <= 1'b0;
                  o_rsp_func <= i_req_func;
                  o_rsp_data <= i_req_diag_data;
                  if (o_listen_only && !(i_req_func == mhr_pkg::FC_DIAG
                                        && i_req_diag_sub == mhr_pkg::SUB_RESTART)) begin
                     o_req_ready <= 1'b1;
                  end else begin
                     state_q <= S_RSP;
                     rd_start_q <= mhr_reg_num(i_req_rd_addr);
                     rd_cnt_q <= i_req_rd_qty;
                     cur_q <= mhr_reg_num(i_req_wr_addr);
                     cnt_q <= i_req_wr_qty;
                     unique case (i_req_func)
                        mhr_pkg::FC_READ: begin
                           if (qty_ok(i_req_rd_qty)) begin
                              cur_q <= mhr_reg_num(i_req_rd_addr);
                              cnt_q <= i_req_rd_qty;
                              state_q <= S_RD;
                           end else exc_q <= mhr_pkg::EXC_VALUE;
                        end
                        mhr_pkg::FC_WRITE_ONE: begin
                           cnt_q <= 16'h0001;
                           state_q <= S_WR;
                        end
                        mhr_pkg::FC_WRITE_MANY: begin
                           if (qty_ok(i_req_wr_qty)) state_q <= S_WR;
                           else exc_q <= mhr_pkg::EXC_VALUE;
                        end
                        mhr_pkg::FC_READ_WRITE: begin
                           if (qty_ok(i_req_wr_qty) && qty_ok(i_req_rd_qty)) begin
                              rd_pend_q <= 1'b1;
                              state_q <= S_WR;
                           end else exc_q <= mhr_pkg::EXC_VALUE;
                        end
                        mhr_pkg::FC_DIAG: begin
                           if (i_req_diag_sub == mhr_pkg::SUB_RESTART) begin
                              restart_pend_q <= 1'b1;
                              if (o_listen_only) state_q <= S_RESTART;
                           end else if (i_req_diag_sub == mhr_pkg::SUB_LISTEN) begin
                              o_listen_only <= 1'b1;
                              state_q <= S_IDLE;
                           end else if (i_req_diag_sub != mhr_pkg::SUB_ECHO) begin
                              exc_q <= mhr_pkg::EXC_FUNC;
                           end
                        end
                        default: exc_q <= mhr_pkg::EXC_FUNC;
                     endcase
                  end
               end
            end
            S_WR: begin
               if (!ph_q) begin
                  ph_q <= 1'b1;
                  o_wdata_ready <= 1'b1;
               end else if (i_wdata_valid) begin
                  o_wdata_ready <= 1'b0;
                  ph_q <= 1'b0;
                  cur_q <= cur_q + 17'h00001;
                  cnt_q <= cnt_q - 16'h0001;
                  if (wr_err != mhr_pkg::EXC_NONE) begin
                     exc_q <= wr_err;
                     state_q <= S_RSP;
                  end else if (cnt_q == 16'h0001) begin
                     if (rd_pend_q) begin
                        cur_q <= rd_start_q;
                        cnt_q <= rd_cnt_q;
                        state_q <= S_RD;
                     end else state_q <= S_RSP;
                  end
               end
            end
            S_RD: begin
               ph_q <= !ph_q;
               if (ph_q) begin
                  cur_q <= cur_q + 17'h00001;
                  cnt_q <= cnt_q - 16'h0001;
                  if (rd_err != mhr_pkg::EXC_NONE) begin
                     exc_q <= rd_err;
                     state_q <= S_RSP;
                  end else begin
                     o_rd_valid <= 1'b1;
                     o_rd_data <= rdata;
                     if (cnt_q == 16'h0001) state_q <= S_RSP;
                  end
               end
            end
            S_RSP: begin
               o_rsp_valid <= 1'b1;
               o_rsp_exc <= exc_q;
               if (exc_q != mhr_pkg::EXC_NONE) o_last_exception_code <= exc_q;
               state_q <= restart_pend_q ? S_RESTART : S_IDLE;
            end
            S_RESTART: begin
               o_comm_restart <= 1'b1;
               o_listen_only <= 1'b0;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Stored words and parameter writes
   // References are kept as raw two's complement words; scaling happens downstream.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_control_word <= mhr_pkg::RESET_WORD;
         o_reference_one <= mhr_pkg::RESET_WORD;
         o_reference_two <= mhr_pkg::RESET_WORD;
         o_wide_control <= {mhr_pkg::RESET_WORD, mhr_pkg::RESET_WORD};
         o_par_wr <= 1'b0;
         o_par_wdata <= mhr_pkg::RESET_WORD;
         o_parameter_save <= 1'b0;
      end else begin
         o_par_wr <= 1'b0;
         o_parameter_save <= 1'b0;
         if (wr_fire) begin
            unique case (kind)
               mhr_pkg::K_CW: o_control_word <= i_wdata;
               mhr_pkg::K_REFERENCE_ONE: o_reference_one <= i_wdata;
               mhr_pkg::K_REFERENCE_TWO: o_reference_two <= i_wdata;
               mhr_pkg::K_WCL: o_wide_control[15:0] <= i_wdata;
               mhr_pkg::K_WCH: o_wide_control[31:16] <= i_wdata;
               mhr_pkg::K_PAR: begin
                  o_par_wr <= 1'b1;
                  o_par_wdata <= i_wdata;
                  o_parameter_save <= (pnum == mhr_pkg::PAR_SAVE) && (i_wdata != 16'h0000);
               end
               default: o_par_wr <= 1'b0;
            endcase
         end
      end
   end
endmodule : mhr_slave

/* tb/mhr_par_host.sv */
// Behavioural parameter store that answers the slave's parameter lookups.
`timescale 1ns/1ns
module mhr_par_host (
   input wire logic i_ref_clk, // Clock
   input wire logic [13:0] i_par_num, // Parameter looked up
   input wire logic i_par_wr, // Volatile write pulse
   input wire logic [15:0] i_par_wdata, // Write value
   output logic o_par_exists, // Parameter exists
   output logic o_par_read_only, // Parameter read-only
   output logic [15:0] o_par_rdata // Parameter value
);
   // ==========================================================================
   // Working copy only: nothing stored here survives a power cycle.
   logic [15:0] mem_q [16] = '{default: 16'h0000};
   assign o_par_exists = i_par_num != 14'h0198;
   assign o_par_read_only = i_par_num == 14'h0066;
   // A missing parameter shows a changing pattern, so a stale value cannot pass.
   assign o_par_rdata = o_par_exists ? mem_q[i_par_num[3:0]] : {2'h0, ~i_par_num};
   always @(posedge i_ref_clk) begin
      if (i_par_wr) begin
         mem_q[i_par_num[3:0]] <= i_par_wdata;
      end
   end
endmodule : mhr_par_host

/* tb/mhr_slave_asserts.sv */
// Concurrent checks on the ports of the holding-register slave.
`timescale 1ns/1ns
module mhr_slave_asserts (
   input wire logic i_ref_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_req_valid, // Request
   input wire logic [7:0] i_req_func, // Function
   input wire logic [15:0] i_req_rd_addr, // Read address
   input wire logic [15:0] i_req_rd_qty, // Read count
   input wire logic [15:0] i_req_wr_qty, // Write count
   input wire logic [15:0] i_req_diag_sub, // Subcode
   input wire logic [15:0] i_req_diag_data, // Diag data
   input wire logic o_req_ready, // Ready
   input wire logic o_rd_valid, // Read strobe
   input wire logic [15:0] o_rd_data, // Read word
   input wire logic o_rsp_valid, // Response
   input wire logic [7:0] o_rsp_exc, // Exception
   input wire logic [15:0] o_rsp_data, // Echo
   input wire logic o_comm_restart, // Restart
   input wire logic o_listen_only, // Listen mode
   input wire logic [7:0] o_last_exception_code, // Last exception
   input wire logic [15:0] o_reference_one // Reference one
);
   // ==========================================================================
   // Shared terms
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   logic take;
   assign take = i_req_valid && o_req_ready && !o_listen_only;
   sequence s_read_one;
      ##3 o_rd_valid && o_rd_data == o_reference_one ##1 o_rsp_valid && o_rsp_exc == 8'h00 ##1 o_req_ready;
   endsequence
   sequence s_wake;
      ##2 o_comm_restart && !o_listen_only;
   endsequence
   // ==========================================================================
   // Properties
   chk_read_word: assert property (
      take && i_req_func == mhr_pkg::FC_READ && i_req_rd_addr == 16'h0001 && i_req_rd_qty == 16'h0001
      |-> s_read_one) else $error("single read of reference one wrong");
   chk_echo_data: assert property (
      take && i_req_func == mhr_pkg::FC_DIAG && i_req_diag_sub == mhr_pkg::SUB_ECHO |-> ##2 o_rsp_valid
      && o_rsp_exc == mhr_pkg::EXC_NONE && o_rsp_data == $past(i_req_diag_data, 2)) else $error("echo wrong");
   chk_bad_func: assert property (
      take && !(i_req_func inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h17})
      |-> ##2 o_rsp_valid && o_rsp_exc == mhr_pkg::EXC_FUNC) else $error("bad function not refused");
   chk_qty_limit: assert property (
      take && i_req_func == mhr_pkg::FC_WRITE_MANY && (i_req_wr_qty == 16'h0000 || i_req_wr_qty > mhr_pkg::MAX_QTY)
      |-> ##2 o_rsp_valid && o_rsp_exc == mhr_pkg::EXC_VALUE) else $error("oversized write not refused");
   chk_listen_enter: assert property (
      take && i_req_func == mhr_pkg::FC_DIAG && i_req_diag_sub == mhr_pkg::SUB_LISTEN
      |=> (o_listen_only && !o_rsp_valid) [*3]) else $error("listen mode not entered quietly");
   chk_listen_quiet: assert property (o_listen_only |-> !o_rsp_valid && !o_rd_valid)
      else $error("answer given in listen mode");
   chk_listen_wake: assert property (
      i_req_valid && o_req_ready && o_listen_only && i_req_func == mhr_pkg::FC_DIAG
      && i_req_diag_sub == mhr_pkg::SUB_RESTART |-> s_wake) else $error("restart from listen mode wrong");
   chk_rsp_first: assert property ($rose(o_comm_restart) && !$past(o_listen_only) |-> $past(o_rsp_valid))
      else $error("restart without prior response");
   chk_last_exc: assert property (
      o_rsp_valid && o_rsp_exc != 8'h00 |-> ##[0:1] o_last_exception_code == o_rsp_exc)
      else $error("last exception not kept");
endmodule : mhr_slave_asserts
bind mhr_slave mhr_slave_asserts u_mhr_slave_asserts (.*);

/* tb/tb_mhr_slave.sv */
// Self-checking bench for the holding-register slave.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_mhr_slave;
   typedef struct {logic [1:0] prof; logic [7:0] func; logic [15:0] addr, wd; logic [7:0] exc; logic [15:0] rd;} mhr_row_s;
   // ==========================================================================
   // Signals
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_wdata_valid = 1'b0;
   logic [7:0] i_req_func = 8'h00;
   logic [15:0] i_req_rd_addr = 16'h0, i_req_rd_qty = 16'h0, i_req_wr_addr = 16'h0, i_req_wr_qty = 16'h0;
   logic [15:0] i_req_diag_sub = 16'h0, i_req_diag_data = 16'h0, i_wdata = 16'h0;
   logic [1:0] i_comm_profile_select = 2'h1;
   logic o_req_ready, o_wdata_ready, o_rd_valid, o_rsp_valid, o_comm_restart, o_listen_only, o_par_wr;
   logic o_parameter_save, i_par_exists, i_par_read_only;
   logic [7:0] o_rsp_func, o_rsp_exc, o_last_exception_code;
   logic [15:0] o_rd_data, o_rsp_data, o_control_word, o_reference_one, o_reference_two, o_par_wdata, i_par_rdata;
   logic [31:0] o_wide_control;
   logic [13:0] o_par_num;
   logic [15:0] wq[$], rq[$];
   int error_cnt = 0, cmp_count = 0, cyc = 0, rst_cnt = 0, save_cnt = 0, n0;
   bit got, tk;
   mhr_row_s rows [20] = '{
      '{2'h1, 8'h06, 16'h0001, 16'h8001, 8'h00, 16'h0}, '{2'h1, 8'h03, 16'h0001, 16'h0, 8'h00, 16'h8001},
      '{2'h1, 8'h06, 16'h0003, 16'h0001, 8'h03, 16'h0}, '{2'h2, 8'h03, 16'h0000, 16'h0, 8'h02, 16'h0},
      '{2'h2, 8'h06, 16'h001E, 16'h1234, 8'h00, 16'h0}, '{2'h2, 8'h03, 16'h0020, 16'h0, 8'h00, 16'h0BAD},
      '{2'h1, 8'h03, 16'h0003, 16'h0, 8'h00, 16'h5A3C}, '{2'h1, 8'h03, 16'h000B, 16'h0, 8'h00, 16'h8888},
      '{2'h1, 8'h03, 16'h0031, 16'h0, 8'h02, 16'h0}, '{2'h1, 8'h03, 16'h0063, 16'h0, 8'h02, 16'h0},
      '{2'h1, 8'h06, 16'h0066, 16'h0042, 8'h00, 16'h0}, '{2'h1, 8'h03, 16'h0066, 16'h0, 8'h00, 16'h0042},
      '{2'h1, 8'h06, 16'h0065, 16'h0007, 8'h03, 16'h0}, '{2'h1, 8'h03, 16'h0197, 16'h0, 8'h02, 16'h0},
      '{2'h1, 8'h06, 16'h0646, 16'h0001, 8'h00, 16'h0}, '{2'h1, 8'h03, 16'h14C5, 16'h0, 8'h00, 16'h0002},
      '{2'h1, 8'h05, 16'h0000, 16'h0, 8'h01, 16'h0}, '{2'h0, 8'h03, 16'h0003, 16'h0, 8'h00, 16'h5A3C},
      '{2'h3, 8'h03, 16'h0000, 16'h0, 8'h02, 16'h0}, '{2'h1, 8'h03, 16'h14C7, 16'h0, 8'h00, 16'h5A3C}};
   mhr_slave u_mhr_slave (.*, .i_status_word(16'h5A3C), .i_wide_status(32'hCAFE_0BAD),
      .i_actual_values(128'h8888_7777_6666_5555_4444_3333_2222_1111));
   mhr_par_host u_mhr_par_host (.i_ref_clk(i_ref_clk), .i_par_num(o_par_num), .i_par_wr(o_par_wr),
      .i_par_wdata(o_par_wdata), .o_par_exists(i_par_exists), .o_par_read_only(i_par_read_only),
      .o_par_rdata(i_par_rdata));
   // ==========================================================================
   // Clock, pulse counters and hang guard
   always #50 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (o_comm_restart === 1'b1) rst_cnt <= rst_cnt + 1;
      if (o_parameter_save === 1'b1) save_cnt <= save_cnt + 1;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   task automatic do_reset();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      `CHK("reset", 51'h0, {o_req_ready, o_listen_only, o_rsp_valid, o_control_word, o_reference_one, o_reference_two})
   endtask : do_reset
   // Holds each write word until it is taken; a silent request ends after 60 cycles.
   task automatic xfer(input logic [7:0] f, input logic [15:0] ra, rn, wa, wn, s, d);
      int n;
      @(posedge i_ref_clk);
      {i_req_func, i_req_rd_addr, i_req_rd_qty, i_req_wr_addr, i_req_wr_qty} <= {f, ra, rn, wa, wn};
      {i_req_diag_sub, i_req_diag_data, i_req_valid} <= {s, d, 1'b1};
      got = 1'b0;
      rq.delete();
      do @(negedge i_ref_clk); while (o_req_ready !== 1'b1);
      @(posedge i_ref_clk);
      i_req_valid <= 1'b0;
      for (n = 0; n < 60 && !got; n++) begin
         {i_wdata_valid, i_wdata} <= (wq.size() > 0) ? {1'b1, wq[0]} : {1'b0, ~i_wdata};
         @(negedge i_ref_clk);
         if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
         got = (o_rsp_valid === 1'b1);
         tk = (o_wdata_ready === 1'b1) && i_wdata_valid;
         @(posedge i_ref_clk);
         if (tk) void'(wq.pop_front());
      end
      i_wdata_valid <= 1'b0;
      wq.delete();
      @(negedge i_ref_clk);
   endtask : xfer
   // ==========================================================================
   // Main sequence
   initial begin
      do_reset();
      foreach (rows[i]) begin
         i_comm_profile_select <= rows[i].prof;
         if (rows[i].func == 8'h06) wq.push_back(rows[i].wd);
         xfer(rows[i].func, rows[i].addr, 16'h0001, rows[i].addr, 16'h0001, 16'h0, 16'h0);
         `CHK("exc", {rows[i].func, rows[i].exc}, {o_rsp_func, o_rsp_exc})
         if (rows[i].func == 8'h03 && rows[i].exc == 8'h00) `CHK("rdata", rows[i].rd, rq[0])
      end
      `CHK("wide", 32'h0000_1234, o_wide_control)
      `CHK("save", 1, save_cnt)
      i_comm_profile_select <= 2'h1;
      wq = '{16'h0F0F, 16'h0005, 16'hFFFB};
      xfer(8'h10, 16'h0, 16'h0, 16'h0000, 16'h0003, 16'h0, 16'h0);
      `CHK("many", 56'h00_0F0F_0005_FFFB, {o_rsp_exc, o_control_word, o_reference_one, o_reference_two})
      xfer(8'h03, 16'h0001, 16'h0003, 16'h0, 16'h0, 16'h0, 16'h0);
      `CHK("multi", 48'h0005_FFFB_5A3C, {rq[0], rq[1], rq[2]})
      xfer(8'h10, 16'h0, 16'h0, 16'h0001, 16'h0079, 16'h0, 16'h0);
      `CHK("long", 8'h03, o_rsp_exc)
      wq = '{16'h7A7A};
      xfer(8'h17, 16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0, 16'h0);
      `CHK("rdwr", 24'h00_7A7A, {o_rsp_exc, rq[0]})
      xfer(8'h08, 16'h0, 16'h0, 16'h0, 16'h0, mhr_pkg::SUB_ECHO, 16'hA55A);
      `CHK("echo", 24'h00_A55A, {o_rsp_exc, o_rsp_data})
      xfer(8'h08, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 16'h0);
      `CHK("sub", 8'h01, o_rsp_exc)
      n0 = rst_cnt;
      xfer(8'h08, 16'h0, 16'h0, 16'h0, 16'h0, mhr_pkg::SUB_RESTART, 16'h0);
      repeat (2) @(negedge i_ref_clk);
      `CHK("restart", 2'b11, {got, rst_cnt == n0 + 1})
      xfer(8'h08, 16'h0, 16'h0, 16'h0, 16'h0, mhr_pkg::SUB_LISTEN, 16'h0);
      `CHK("listen", 2'b01, {got, o_listen_only})
      xfer(8'h03, 16'h0001, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0);
      `CHK("ignored", 2'b00, {got, rq.size() != 0})
      n0 = rst_cnt;
      xfer(8'h08, 16'h0, 16'h0, 16'h0, 16'h0, mhr_pkg::SUB_RESTART, 16'h0);
      repeat (2) @(negedge i_ref_clk);
      `CHK("wake", 3'b001, {got, o_listen_only, rst_cnt == n0 + 1})
      do_reset();
      final_report();
   end
endmodule : tb_mhr_slave
